//--- hw/mlra_pkg.sv
// Constants for the per-level register file with block and inter-level access
package mlra_pkg;
    localparam int unsigned NUM_LEVELS = 16;
    localparam int unsigned BLOCK_WORDS = 8;
    localparam logic [15:0] REG_RESET = 16'h0000;
    localparam logic [2:0] IDX_RESET = 3'h0;
    localparam logic [2:0] IDX_LAST = 3'h7;
    // Slot index inside a level, equal to the position within a block transfer
    localparam logic [2:0] SLOT_P = 3'h0;
    localparam logic [2:0] SLOT_X = 3'h1;
    localparam logic [2:0] SLOT_T = 3'h2;
    localparam logic [2:0] SLOT_A = 3'h3;
    localparam logic [2:0] SLOT_D = 3'h4;
    localparam logic [2:0] SLOT_L = 3'h5;
    localparam logic [2:0] SLOT_STS = 3'h6;
    localparam logic [2:0] SLOT_B = 3'h7;
    // Register select field codes, as used for ordinary destination registers
    localparam logic [2:0] SEL_STS = 3'h0;
    localparam logic [2:0] SEL_D = 3'h1;
    localparam logic [2:0] SEL_P = 3'h2;
    localparam logic [2:0] SEL_B = 3'h3;
    localparam logic [2:0] SEL_L = 3'h4;
    localparam logic [2:0] SEL_A = 3'h5;
    localparam logic [2:0] SEL_T = 3'h6;
    localparam logic [2:0] SEL_X = 3'h7;
    // Opcode patterns
    localparam logic [15:0] BLK_MASK = 16'hff87;
    localparam logic [15:0] BLK_STORE_CODE = 16'hd502;
    localparam logic [15:0] BLK_LOAD_CODE = 16'hd580;
    localparam logic [15:0] ILR_MASK = 16'hff80;
    localparam logic [15:0] ILR_READ_CODE = 16'hd780;
    // Field positions
    localparam int unsigned LEVEL_LSB = 3;
    localparam int unsigned SEL_LSB = 0;
    localparam logic [1:0] RING_SYSTEM_MIN = 2'h2;

    typedef enum {ST_IDLE, ST_STORE, ST_LOAD, ST_DONE} mlra_state_t;

    function automatic logic [2:0] sel_to_slot(input logic [2:0] sel);
        logic [2:0] s;
        s = mlra_pkg::SLOT_STS;
        case (sel)
            mlra_pkg::SEL_STS: s = mlra_pkg::SLOT_STS;
            mlra_pkg::SEL_D: s = mlra_pkg::SLOT_D;
            mlra_pkg::SEL_P: s = mlra_pkg::SLOT_P;
            mlra_pkg::SEL_B: s = mlra_pkg::SLOT_B;
            mlra_pkg::SEL_L: s = mlra_pkg::SLOT_L;
            mlra_pkg::SEL_A: s = mlra_pkg::SLOT_A;
            mlra_pkg::SEL_T: s = mlra_pkg::SLOT_T;
            default: s = mlra_pkg::SLOT_X;
        endcase
        return s;
    endfunction

    function automatic logic [6:0] reg_index(input logic [3:0] level, input logic [2:0] slot);
        return {level, slot};
    endfunction

    // Status holds eight bits; the upper byte is always zero on the way out
    function automatic logic [15:0] sts_view(input logic [15:0] v);
        return {8'h00, v[7:0]};
    endfunction
endpackage

//--- hw/mlra_decode.sv
// Instruction decode and privilege check for the register file
`timescale 1ns/100ps
module mlra_decode (
    input wire logic [15:0] instr,
    input wire logic [1:0] ring,
    input wire logic stop_mode,
    output logic is_store,
    output logic is_load,
    output logic is_read,
    output logic priv_ok,
    output logic [3:0] level,
    output logic [2:0] slot,
    output logic sel_is_sts
);
    wire logic [2:0] sel_field;

    assign is_store = (instr & mlra_pkg::BLK_MASK) == mlra_pkg::BLK_STORE_CODE;
    assign is_load = (instr & mlra_pkg::BLK_MASK) == mlra_pkg::BLK_LOAD_CODE;
    assign is_read = (instr & mlra_pkg::ILR_MASK) == mlra_pkg::ILR_READ_CODE;
    assign priv_ok = (ring >= mlra_pkg::RING_SYSTEM_MIN) || stop_mode;
    assign level = instr[mlra_pkg::LEVEL_LSB +: 4];
    assign sel_field = instr[mlra_pkg::SEL_LSB +: 3];
    assign slot = mlra_pkg::sel_to_slot(sel_field);
    assign sel_is_sts = sel_field == mlra_pkg::SEL_STS;
endmodule

//--- hw/mlra_regfile.sv
// Sixteen-level register file with block store, block load and inter-level read
// What this block does
// - Privileged instructions run only in ring 2 or 3 or in stop mode.
// - There are sixteen independent register sets, one per program level.
// - A block moves in the order P, X, T, A, D, L, status, B.
// - In a block the status word carries the status bits low and zero in bits 8-15.
// - Block transfers start at the address held in the current level's X register.
// - Block store writes the selected level's eight registers to successive words.
// - Block store of the running level writes the address of the next instruction as P.
// - Block load fills the selected level's registers from successive words, all eight unless it is the running level.
// - Block load of the running level leaves its P untouched.
// - Instruction bits 3-6 name the target level.
// - Instruction bits 0-2 select the register with the destination register encoding.
// - Inter-level access accepts any level, the running one included.
// - Inter-level read copies the selected register of the target level into current A.
// - With select zero, inter-level read puts status in A bits 0-7 and clears bits 8-15.
`timescale 1ns/100ps
module mlra_regfile (
    input wire logic core_clk,
    input wire logic rst_n,
    input wire logic instr_valid,
    input wire logic [15:0] instr,
    input wire logic [15:0] next_pc,
    input wire logic [3:0] cur_level,
    input wire logic [1:0] ring,
    input wire logic stop_mode,
    input wire logic wr_en,
    input wire logic [3:0] wr_level,
    input wire logic [2:0] wr_slot,
    input wire logic [15:0] wr_data,
    input wire logic [3:0] rd_level,
    input wire logic [2:0] rd_slot,
    input wire logic mem_ack,
    input wire logic [15:0] mem_rdata,
    output logic busy,
    output logic instr_done,
    output logic prot_viol,
    output logic mem_req,
    output logic mem_we,
    output logic [15:0] mem_addr,
    output logic [15:0] mem_wdata,
    output logic [15:0] rd_data
);
    logic [15:0] regs_r [0:127];
    mlra_pkg::mlra_state_t state_r;
    mlra_pkg::mlra_state_t state_nxt;
    logic [2:0] idx_r;
    logic [3:0] tgt_level_r;
    logic cur_same_r;
    logic [15:0] base_r;
    logic [15:0] pc_next_r;
    logic busy_r;
    logic done_r;
    logic viol_r;
    logic mem_req_r;
    logic mem_we_r;
    logic [15:0] mem_addr_r;
    logic [15:0] mem_wdata_r;
    logic [15:0] rd_data_r;

    wire logic dec_store;
    wire logic dec_load;
    wire logic dec_read;
    wire logic dec_priv;
    wire logic [3:0] dec_level;
    wire logic [2:0] dec_slot;
    wire logic dec_sts;

    mlra_decode u_decode (
        .instr(instr),
        .ring(ring),
        .stop_mode(stop_mode),
        .is_store(dec_store),
        .is_load(dec_load),
        .is_read(dec_read),
        .priv_ok(dec_priv),
        .level(dec_level),
        .slot(dec_slot),
        .sel_is_sts(dec_sts)
    );

    // Instructions are taken only while idle; the decoder must hold off otherwise
    wire logic idle = state_r == mlra_pkg::ST_IDLE;
    wire logic priv_instr = dec_store || dec_load || dec_read;
    wire logic take = instr_valid && idle && priv_instr;
    wire logic go_ok = take && dec_priv;
    wire logic go_viol = take && !dec_priv;
    wire logic go_store = go_ok && dec_store;
    wire logic go_load = go_ok && dec_load;
    wire logic go_read = go_ok && dec_read;
    wire logic [15:0] cur_x = regs_r[mlra_pkg::reg_index(cur_level, mlra_pkg::SLOT_X)];
    wire logic [15:0] rd_src = regs_r[mlra_pkg::reg_index(dec_level, dec_slot)];
    wire logic [15:0] irr_val = dec_sts ? mlra_pkg::sts_view(rd_src) : rd_src;
    wire logic step = mem_req_r && mem_ack;
    wire logic last = idx_r == mlra_pkg::IDX_LAST;
    wire logic [2:0] idx_next = idx_r + 3'h1;

    // Store data for a given slot of the target level
    function automatic logic [15:0] store_word(input logic [2:0] slot, input logic [3:0] lvl,
                                               input logic same, input logic [15:0] pc_nx);
        logic [15:0] v;
        v = regs_r[mlra_pkg::reg_index(lvl, slot)];
        if (slot == mlra_pkg::SLOT_STS) begin
            v = mlra_pkg::sts_view(v);
        end else if (slot == mlra_pkg::SLOT_P && same) begin
            v = pc_nx;
        end
        return v;
    endfunction

    // One write port into the array; the fsm wins over the external port
    wire logic load_we = state_r == mlra_pkg::ST_LOAD && step && !(cur_same_r && idx_r == mlra_pkg::SLOT_P);
    wire logic ext_we = wr_en && !load_we && !go_read && !busy_r;
    wire logic arr_we = load_we || go_read || ext_we;
    wire logic [6:0] arr_idx = load_we ? mlra_pkg::reg_index(tgt_level_r, idx_r) :
                               go_read ? mlra_pkg::reg_index(cur_level, mlra_pkg::SLOT_A) :
                               mlra_pkg::reg_index(wr_level, wr_slot);
    wire logic [15:0] arr_wdata = load_we ? (idx_r == mlra_pkg::SLOT_STS ? mlra_pkg::sts_view(mem_rdata) : mem_rdata) :
                                  go_read ? irr_val : wr_data;

    always_comb begin
        state_nxt = state_r;
        case (state_r)
            mlra_pkg::ST_IDLE: begin
                if (go_store) begin
                    state_nxt = mlra_pkg::ST_STORE;
                end else if (go_load) begin
                    state_nxt = mlra_pkg::ST_LOAD;
                end else if (go_read || go_viol) begin
                    state_nxt = mlra_pkg::ST_DONE;
                end
            end
            mlra_pkg::ST_STORE, mlra_pkg::ST_LOAD: begin
                if (step && last) begin
                    state_nxt = mlra_pkg::ST_DONE;
                end
            end
            mlra_pkg::ST_DONE: state_nxt = mlra_pkg::ST_IDLE;
            default: state_nxt = mlra_pkg::ST_IDLE;
        endcase
    end

    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            for (int i = 0; i < 128; i++) begin
                regs_r[i] <= mlra_pkg::REG_RESET;
            end
        end else if (arr_we) begin
            regs_r[arr_idx] <= arr_wdata;
        end
    end

    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            state_r <= mlra_pkg::ST_IDLE;
            idx_r <= mlra_pkg::IDX_RESET;
            tgt_level_r <= 4'h0;
            cur_same_r <= 1'b0;
            base_r <= mlra_pkg::REG_RESET;
            pc_next_r <= mlra_pkg::REG_RESET;
        end else begin
            state_r <= state_nxt;
            if (go_store || go_load) begin
                idx_r <= mlra_pkg::IDX_RESET;
                tgt_level_r <= dec_level;
                cur_same_r <= dec_level == cur_level;
                base_r <= cur_x;
                pc_next_r <= next_pc;
            end else if (step) begin
                idx_r <= idx_next;
            end
        end
    end

    // Bus outputs; the base is latched so that loading X mid-block cannot move the window
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            mem_req_r <= 1'b0;
            mem_we_r <= 1'b0;
            mem_addr_r <= mlra_pkg::REG_RESET;
            mem_wdata_r <= mlra_pkg::REG_RESET;
        end else if (go_store || go_load) begin
            mem_req_r <= 1'b1;
            mem_we_r <= go_store;
            mem_addr_r <= cur_x;
            mem_wdata_r <= go_store ? store_word(mlra_pkg::SLOT_P, dec_level, dec_level == cur_level, next_pc) :
                           mlra_pkg::REG_RESET;
        end else if (step) begin
            mem_req_r <= !last;
            mem_we_r <= mem_we_r && !last;
            mem_addr_r <= base_r + {13'h0000, idx_next};
            mem_wdata_r <= mem_we_r ? store_word(idx_next, tgt_level_r, cur_same_r, pc_next_r) :
                           mlra_pkg::REG_RESET;
        end
    end

    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            busy_r <= 1'b0;
            done_r <= 1'b0;
            viol_r <= 1'b0;
            rd_data_r <= mlra_pkg::REG_RESET;
        end else begin
            busy_r <= state_nxt != mlra_pkg::ST_IDLE;
            done_r <= state_nxt == mlra_pkg::ST_DONE;
            viol_r <= go_viol;
            rd_data_r <= regs_r[mlra_pkg::reg_index(rd_level, rd_slot)];
        end
    end

    assign busy = busy_r;
    assign instr_done = done_r;
    assign prot_viol = viol_r;
    assign mem_req = mem_req_r;
    assign mem_we = mem_we_r;
    assign mem_addr = mem_addr_r;
    assign mem_wdata = mem_wdata_r;
    assign rd_data = rd_data_r;

    // Checks

    // Counts acknowledged words apart from idx_r, so a wrapped index cannot hide a short block
    logic [3:0] words_r;
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            words_r <= 4'h0;
        end else if (go_store || go_load) begin
            words_r <= 4'h0;
        end else if (step) begin
            words_r <= words_r + 4'h1;
        end
    end

    a_viol_no_bus: assert property (@(posedge core_clk) disable iff (!rst_n)
        go_viol |=> (prot_viol && !mem_req) ##1 !busy)
        else $error("unprivileged attempt started a transfer");
    a_priv_gate: assert property (@(posedge core_clk) disable iff (!rst_n)
        (take && ring < mlra_pkg::RING_SYSTEM_MIN && !stop_mode) |=> !mem_req && prot_viol)
        else $error("privileged instruction ran in user mode");
    a_first_addr: assert property (@(posedge core_clk) disable iff (!rst_n)
        (go_store || go_load) |=> mem_req && mem_addr == $past(cur_x))
        else $error("block did not start at X");
    a_addr_order: assert property (@(posedge core_clk) disable iff (!rst_n)
        mem_req |-> mem_addr == base_r + {13'h0000, idx_r})
        else $error("block word address out of order");
    a_sts_upper_zero: assert property (@(posedge core_clk) disable iff (!rst_n)
        (mem_req && mem_we && idx_r == mlra_pkg::SLOT_STS) |-> mem_wdata[15:8] == 8'h00)
        else $error("status word upper byte not zero");
    a_pc_next_store: assert property (@(posedge core_clk) disable iff (!rst_n)
        (go_store && dec_level == cur_level) |=> mem_wdata == $past(next_pc))
        else $error("stored P is not the following instruction");
    a_load_pc_kept: assert property (@(posedge core_clk) disable iff (!rst_n)
        (state_r == mlra_pkg::ST_LOAD && cur_same_r && idx_r == mlra_pkg::SLOT_P && step)
        |=> $stable(regs_r[mlra_pkg::reg_index(tgt_level_r, mlra_pkg::SLOT_P)]))
        else $error("block load changed running P");
    a_irr_copy: assert property (@(posedge core_clk) disable iff (!rst_n)
        go_read |=> regs_r[$past(arr_idx)] == $past(irr_val) && instr_done)
        else $error("inter-level read did not reach A");
    a_irr_sts_zero: assert property (@(posedge core_clk) disable iff (!rst_n)
        (go_read && dec_sts) |=> regs_r[$past(arr_idx)][15:8] == 8'h00)
        else $error("status read left upper bits set");
    a_eight_words: assert property (@(posedge core_clk) disable iff (!rst_n)
        (step && last) |=> !mem_req && instr_done)
        else $error("block did not end after eight words");

    // Checked at the array and the bus, since the muxes in front of them are what can go wrong
    a_block_len: assert property (@(posedge core_clk) disable iff (!rst_n)
        (step && last) |=> words_r == 4'(mlra_pkg::BLOCK_WORDS))
        else $error("block length is not eight words");
    a_load_sts_clear: assert property (@(posedge core_clk) disable iff (!rst_n)
        (load_we && idx_r == mlra_pkg::SLOT_STS) |=> regs_r[$past(arr_idx)][15:8] == 8'h00)
        else $error("loaded status kept upper bits");
    a_load_word: assert property (@(posedge core_clk) disable iff (!rst_n)
        (load_we && idx_r != mlra_pkg::SLOT_STS) |=> regs_r[$past(arr_idx)] == $past(mem_rdata))
        else $error("loaded word did not land");
    a_load_level: assert property (@(posedge core_clk) disable iff (!rst_n)
        (go_store || go_load) |=> tgt_level_r == $past(instr[mlra_pkg::LEVEL_LSB +: 4]))
        else $error("block level not taken from the level field");
    a_store_word: assert property (@(posedge core_clk) disable iff (!rst_n)
        (mem_req && mem_we && idx_r != mlra_pkg::SLOT_STS && !(cur_same_r && idx_r == mlra_pkg::SLOT_P))
        |-> mem_wdata == regs_r[mlra_pkg::reg_index(tgt_level_r, idx_r)])
        else $error("stored word is not the level's register");
    a_viol_source: assert property (@(posedge core_clk) disable iff (!rst_n)
        prot_viol |-> $past(instr_valid) && $past(ring) < mlra_pkg::RING_SYSTEM_MIN && !$past(stop_mode))
        else $error("violation flagged without an unprivileged attempt");
    a_viol_keeps_a: assert property (@(posedge core_clk) disable iff (!rst_n)
        (go_viol && !wr_en) |=> $stable(regs_r[mlra_pkg::reg_index(cur_level, mlra_pkg::SLOT_A)]))
        else $error("unprivileged attempt changed A");
    a_sel_decode: assert property (@(posedge core_clk) disable iff (!rst_n)
        (go_read && instr[mlra_pkg::SEL_LSB +: 3] == mlra_pkg::SEL_B)
        |-> rd_src == regs_r[mlra_pkg::reg_index(dec_level, mlra_pkg::SLOT_B)])
        else $error("select code did not reach B");

    c_store: cover property (@(posedge core_clk) disable iff (!rst_n) go_store ##[1:40] instr_done);
    c_load_same: cover property (@(posedge core_clk) disable iff (!rst_n)
        go_load && dec_level == cur_level ##[1:40] instr_done);
    c_read_sts: cover property (@(posedge core_clk) disable iff (!rst_n) go_read && dec_sts);
    c_viol: cover property (@(posedge core_clk) disable iff (!rst_n) go_viol);
    c_load_other: cover property (@(posedge core_clk) disable iff (!rst_n)
        go_load && dec_level != cur_level ##[1:40] instr_done);
endmodule

//--- tb/mlra_mem_model.sv
// Behavioural main memory answering the register file's word requests
`timescale 1ns/100ps
module mlra_mem_model (
    input wire logic core_clk,
    input wire logic rst_n,
    input wire logic [3:0] wait_cycles,
    input wire logic mem_req,
    input wire logic mem_we,
    input wire logic [15:0] mem_addr,
    input wire logic [15:0] mem_wdata,
    output logic mem_ack,
    output logic [15:0] mem_rdata
);
    logic [15:0] mem [0:255];
    logic [3:0] wait_r;
    // Read data toggles outside the ack cycle so a stale word never passes for a fresh one
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            mem_ack <= 1'b0;
            mem_rdata <= 16'h0000;
            wait_r <= 4'h0;
        end else if (mem_req && !mem_ack && wait_r >= wait_cycles) begin
            mem_ack <= 1'b1;
            wait_r <= 4'h0;
            if (mem_we) mem[mem_addr[7:0]] <= mem_wdata;
            else mem_rdata <= mem[mem_addr[7:0]];
        end else begin
            mem_ack <= 1'b0;
            mem_rdata <= ~mem_rdata;
            if (mem_req && !mem_ack) wait_r <= wait_r + 4'h1;
        end
    end
endmodule

//--- tb/tb_top.sv
// Self-checking bench for the per-level register file
`timescale 1ns/100ps
module tb_top;
    typedef struct packed {logic [15:0] instr; logic [15:0] exp;} mlra_row_t;
    logic core_clk, rst_n, instr_valid, stop_mode, wr_en, mem_ack, busy, instr_done, prot_viol, mem_req, mem_we;
    logic [15:0] instr, next_pc, wr_data, mem_rdata, mem_addr, mem_wdata, rd_data;
    logic [3:0] cur_level, wr_level, rd_level, slow;
    logic [2:0] wr_slot, rd_slot;
    logic [1:0] ring;
    logic seen_viol;
    int errors = 0;
    int n_compared = 0;
    // Select codes 0..7 on level 3, with the slot each one must reach
    mlra_row_t rows [8] = '{'{16'hd798, 16'h005c}, '{16'hd799, 16'h3a04}, '{16'hd79a, 16'h3a00},
        '{16'hd79b, 16'h3a07}, '{16'hd79c, 16'h3a05}, '{16'hd79d, 16'h3a03}, '{16'hd79e, 16'h3a02},
        '{16'hd79f, 16'h3a01}};
    logic [15:0] blk_exp [8] = '{16'h3a00, 16'h3a01, 16'h3a02, 16'h3a03, 16'h3a04, 16'h3a05, 16'h005c, 16'h3a07};

    mlra_regfile DUT (.core_clk(core_clk), .rst_n(rst_n), .instr_valid(instr_valid), .instr(instr),
        .next_pc(next_pc), .cur_level(cur_level), .ring(ring), .stop_mode(stop_mode), .wr_en(wr_en),
        .wr_level(wr_level), .wr_slot(wr_slot), .wr_data(wr_data), .rd_level(rd_level), .rd_slot(rd_slot),
        .mem_ack(mem_ack), .mem_rdata(mem_rdata), .busy(busy), .instr_done(instr_done), .prot_viol(prot_viol),
        .mem_req(mem_req), .mem_we(mem_we), .mem_addr(mem_addr), .mem_wdata(mem_wdata), .rd_data(rd_data));
    mlra_mem_model MEM (.core_clk(core_clk), .rst_n(rst_n), .wait_cycles(slow), .mem_req(mem_req),
        .mem_we(mem_we), .mem_addr(mem_addr), .mem_wdata(mem_wdata), .mem_ack(mem_ack), .mem_rdata(mem_rdata));

    task automatic check(input string name, input logic [15:0] seen, input logic [15:0] exp);
        n_compared++;
        if (seen !== exp) begin
            errors++;
            $display("wrong value %s expected %h seen %h", name, exp, seen);
        end
    endtask
    task automatic wr_reg(input logic [3:0] lv, input logic [2:0] sl, input logic [15:0] d);
        @(posedge core_clk);
        wr_en <= 1'b1;
        wr_level <= lv;
        wr_slot <= sl;
        wr_data <= d;
        @(posedge core_clk);
        wr_en <= 1'b0;
    endtask
    task automatic rd_chk(input string name, input logic [3:0] lv, input logic [2:0] sl, input logic [15:0] exp);
        @(posedge core_clk);
        rd_level <= lv;
        rd_slot <= sl;
        @(posedge core_clk);
        #1;
        check(name, rd_data, exp);
    endtask
    // Waits for completion under a bound, so a lost instruction cannot hang the run
    task automatic run(input logic [15:0] w);
        int k;
        @(posedge core_clk);
        instr_valid <= 1'b1;
        instr <= w;
        @(posedge core_clk);
        instr_valid <= 1'b0;
        for (k = 0; k < 400; k++) begin
            #1;
            if (instr_done === 1'b1) break;
            @(posedge core_clk);
        end
        seen_viol = prot_viol;
        check("instr_done", {15'h0000, instr_done}, 16'h0001);
        @(posedge core_clk);
    endtask
    task automatic tally_and_finish();
        $display("compared %0d mismatches %0d", n_compared, errors);
        if (errors == 0 && n_compared > 0) $display("Test passed");
        else $display("Test failed");
        $finish;
    endtask

    initial begin
        core_clk = 1'b0;
        forever #25 core_clk = ~core_clk;
    end
    initial begin
        #(50 * 30000);
        errors++;
        tally_and_finish();
    end
    initial begin
        {rst_n, instr_valid, stop_mode, wr_en} = 4'h0;
        {instr, next_pc, wr_data} = {16'h0000, 16'h0000, 16'h0000};
        {cur_level, wr_level, rd_level, slow} = 16'h1000;
        {wr_slot, rd_slot, ring} = 8'h03;
        repeat (16) @(posedge core_clk);
        rst_n <= 1'b1;
        #1;
        check("busy", {15'h0000, busy}, 16'h0000);
        check("mem_req", {15'h0000, mem_req}, 16'h0000);
        rd_chk("reset_reg", 4'h3, mlra_pkg::SLOT_B, 16'h0000);
        $display("test reset done");
        for (int s = 0; s < 8; s++) wr_reg(4'h3, s[2:0], (s == 6) ? 16'h7f5c : (16'h3a00 | 16'(s)));
        wr_reg(4'hb, mlra_pkg::SLOT_A, 16'hbbbb);
        wr_reg(4'h1, mlra_pkg::SLOT_P, 16'h1111);
        wr_reg(4'h1, mlra_pkg::SLOT_X, 16'h0040);
        rd_chk("lvl3_a", 4'h3, mlra_pkg::SLOT_A, 16'h3a03);
        rd_chk("lvl11_a", 4'hb, mlra_pkg::SLOT_A, 16'hbbbb);
        for (int i = 0; i < 8; i++) begin
            run(rows[i].instr);
            rd_chk("read_to_a", 4'h1, mlra_pkg::SLOT_A, rows[i].exp);
        end
        run(16'hd78f);
        rd_chk("read_own", 4'h1, mlra_pkg::SLOT_A, 16'h0040);
        $display("test inter-level read done");
        slow <= 4'h2;
        run(16'hd51a);
        for (int i = 0; i < 8; i++) check("store_word", MEM.mem[64 + i], blk_exp[i]);
        wr_reg(4'h1, mlra_pkg::SLOT_X, 16'h0050);
        next_pc <= 16'h2468;
        run(16'hd50a);
        check("store_own_p", MEM.mem[80], 16'h2468);
        check("store_own_x", MEM.mem[81], 16'h0050);
        $display("test block store done");
        ring <= 2'h1;
        run(16'hd79d);
        check("viol", {15'h0000, seen_viol}, 16'h0001);
        rd_chk("viol_a", 4'h1, mlra_pkg::SLOT_A, 16'h0040);
        ring <= 2'h0;
        stop_mode <= 1'b1;
        run(16'hd79d);
        check("stop_viol", {15'h0000, seen_viol}, 16'h0000);
        rd_chk("stop_a", 4'h1, mlra_pkg::SLOT_A, 16'h3a03);
        stop_mode <= 1'b0;
        ring <= 2'h2;
        $display("test privilege done");
        wr_reg(4'h1, mlra_pkg::SLOT_X, 16'h0040);
        slow <= 4'h0;
        run(16'hd5a8);
        for (int i = 0; i < 8; i++) rd_chk("load_reg", 4'h5, i[2:0], blk_exp[i]);
        run(16'hd588);
        rd_chk("load_own_p", 4'h1, mlra_pkg::SLOT_P, 16'h1111);
        rd_chk("load_own_x", 4'h1, mlra_pkg::SLOT_X, 16'h3a01);
        rd_chk("load_own_sts", 4'h1, mlra_pkg::SLOT_STS, 16'h005c);
        $display("test block load done");
        // Reset in mid-block must drop the bus at once and clear every level
        @(posedge core_clk);
        instr_valid <= 1'b1;
        instr <= 16'hd51a;
        @(posedge core_clk);
        instr_valid <= 1'b0;
        repeat (3) @(posedge core_clk);
        #1;
        check("mid_req", {15'h0000, mem_req}, 16'h0001);
        @(posedge core_clk);
        rst_n <= 1'b0;
        @(posedge core_clk);
        rst_n <= 1'b1;
        #1;
        check("mid_busy", {15'h0000, busy}, 16'h0000);
        check("mid_mem_req", {15'h0000, mem_req}, 16'h0000);
        rd_chk("mid_clear", 4'h3, mlra_pkg::SLOT_A, 16'h0000);
        run(16'hd79d);
        rd_chk("mid_read", 4'h1, mlra_pkg::SLOT_A, 16'h0000);
        $display("test reset in mid-block done");
        tally_and_finish();
    end
endmodule
